// ### six_output_clock_gate.sv
`timescale 1ns/1ps
`default_nettype none

module six_output_clock_gate #(
  parameter int VARIANT = fanout_gate_pkg::VARIANT_BASE, // Enable behaviour
  parameter bit REF_SOURCE = fanout_gate_pkg::REF_SRC_CRYSTAL, // Reference pin
  parameter int SETTLE_CYCLES = fanout_gate_pkg::OSC_SETTLE_CYCLES // Settle count
) (
  input wire logic mclk_in,                  // System clock, 100 MHz
  input wire logic rst_n_in,                 // Asynchronous reset, active low
  input wire logic global_run_enable_in,     // Gates outputs 0 to 4, high runs
  input wire logic last_output_enable_in,    // Gates output five, high runs
  input wire logic ref_clock_in,             // Logic-level reference input
  input wire logic crystal_input_in,         // Crystal oscillator waveform
  output logic [5:0] fanout_clk_out,         // Gated copies, bit 5 is output_five
  output logic osc_on_out,                   // Oscillator enable, high runs
  output logic settling_out                  // High while the oscillator settles
);

  localparam int N = fanout_gate_pkg::NUM_OUTPUTS;
  localparam int FIVE = fanout_gate_pkg::OUTPUT_FIVE_IDX;
  localparam logic [fanout_gate_pkg::SETTLE_CNT_W-1:0] SETTLE_LOAD =
    fanout_gate_pkg::SETTLE_CNT_W'(SETTLE_CYCLES);

  logic g_s1; // First stage, global enable
  logic g_s2; // Synchronised global enable
  logic l_s1; // First stage, last-output enable
  logic l_s2; // Synchronised last-output enable
  logic osc_on; // Oscillator running
  logic [fanout_gate_pkg::SETTLE_CNT_W-1:0] settle_cnt; // Settle countdown
  logic ref_level; // Sampled reference
  logic next_osc_on; // Oscillator state for the next edge
  logic settle_busy; // Settle count not yet expired
  logic ref_raw; // Selected reference pin
  logic next_ref_level; // Reference after oscillator gating
  logic run_low; // Outputs 0 to 4 requested
  logic run_five; // Output five requested
  logic osc_req; // Oscillator wanted by the enables
  logic [5:0] run_vec; // Per-output run request
  logic [5:0] gate_vec; // Per-output gate state

  // Two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      g_s1 <= fanout_gate_pkg::SYNC_RESET_VAL;
      g_s2 <= fanout_gate_pkg::SYNC_RESET_VAL;
      l_s1 <= fanout_gate_pkg::SYNC_RESET_VAL;
      l_s2 <= fanout_gate_pkg::SYNC_RESET_VAL;
    end else begin
      g_s1 <= global_run_enable_in;
      g_s2 <= g_s1;
      l_s1 <= last_output_enable_in;
      l_s2 <= l_s1;
    end
  end

  // Oscillator wanted per variant; high enables run, low stops
  assign osc_req = g_s2
    || ((VARIANT == fanout_gate_pkg::VARIANT_KEEP_FIVE) && l_s2)
    || (VARIANT == fanout_gate_pkg::VARIANT_OSC_ALWAYS);

  // A stop waits until every gate is shut: cutting the reference under an
  // open gate would leave a runt on the outputs
  assign next_osc_on = osc_req || (osc_on && (gate_vec != 6'h00));

  // Output requests per variant
  assign run_low = g_s2 && !settle_busy;
  assign run_five = l_s2 && !settle_busy
    && (g_s2 || (VARIANT != fanout_gate_pkg::VARIANT_BASE));
  assign run_vec = {run_five, {(N - 1){run_low}}};

  // Reference source; a stopped crystal yields a flat low level
  assign ref_raw = (REF_SOURCE == fanout_gate_pkg::REF_SRC_CRYSTAL) ?
    crystal_input_in : ref_clock_in;
  assign next_ref_level = ref_raw && osc_on;
  assign settle_busy = (settle_cnt != '0);

  // Oscillator state and settle counter, restarted on every wake-up
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_on <= 1'b0;
      settle_cnt <= '0;
      ref_level <= 1'b0;
    end else begin
      osc_on <= next_osc_on;
      ref_level <= next_ref_level;
      if (next_osc_on && !osc_on) begin
        settle_cnt <= SETTLE_LOAD;
      end else if (settle_busy) begin
        settle_cnt <= settle_cnt - 1'b1;
      end
    end
  end

  // One gate per output copy; all share the same reference sample for low skew
  for (genvar i = 0; i < N; i++) begin : g_cell
    clk_gate_cell u_cell (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .ref_level_in(ref_level),
      .run_in(run_vec[i]),
      .gate_out(gate_vec[i]),
      .clk_out(fanout_clk_out[i])
    );
  end

  assign osc_on_out = osc_on;
  assign settling_out = settle_busy;

  // Gate moves only while the reference is low
  property p_gate_moves_low;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (gate_vec != $past(gate_vec)) |-> !$past(ref_level);
  endproperty
  a_gate_moves_low: assert property (p_gate_moves_low)
    else $error("gate changed while reference high");

  // A rising output 0 always comes from a high reference sample with its gate open
  property p_whole_pulse;
    @(posedge mclk_in) disable iff (!rst_n_in)
      $rose(fanout_clk_out[0]) |-> $past(ref_level) && $past(gate_vec[0]);
  endproperty
  a_whole_pulse: assert property (p_whole_pulse)
    else $error("output rose without a full reference pulse");

  // Base variant sleeps when the global enable is low
  property p_base_sleep;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (VARIANT == fanout_gate_pkg::VARIANT_BASE && !g_s2 && (gate_vec == 6'h00))
        |=> !osc_on_out;
  endproperty
  a_base_sleep: assert property (p_base_sleep)
    else $error("oscillator still on in sleep");

  // The oscillator only stops once every gate is shut
  property p_osc_stop_shut;
    @(posedge mclk_in) disable iff (!rst_n_in)
      $fell(osc_on_out) |-> ($past(gate_vec) == 6'h00);
  endproperty
  a_osc_stop_shut: assert property (p_osc_stop_shut)
    else $error("oscillator stopped with a gate open");

  // Last-output enable low closes gate five at the next low reference
  property p_five_off;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (!l_s2 && !ref_level) |=> !gate_vec[FIVE];
  endproperty
  a_five_off: assert property (p_five_off)
    else $error("output five gate stayed open");

  // Output five alone keeps the oscillator running
  property p_five_alone;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (VARIANT != fanout_gate_pkg::VARIANT_BASE && !g_s2 && l_s2) |=> osc_on_out;
  endproperty
  a_five_alone: assert property (p_five_alone)
    else $error("oscillator stopped while output five runs");

  // Third variant never stops the oscillator
  property p_osc_always;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (VARIANT == fanout_gate_pkg::VARIANT_OSC_ALWAYS) |=> osc_on_out;
  endproperty
  a_osc_always: assert property (p_osc_always)
    else $error("oscillator stopped in always-on variant");

  // Global enable high keeps the oscillator on
  property p_global_osc;
    @(posedge mclk_in) disable iff (!rst_n_in)
      g_s2 |=> osc_on_out;
  endproperty
  a_global_osc: assert property (p_global_osc)
    else $error("oscillator off with global enable high");

  // Both enables high and settled: all gates open at a low reference
  sequence s_all_enabled;
    g_s2 && l_s2 && !settle_busy && !ref_level;
  endsequence
  property p_all_run;
    @(posedge mclk_in) disable iff (!rst_n_in)
      s_all_enabled |=> (gate_vec == 6'h3F);
  endproperty
  a_all_run: assert property (p_all_run)
    else $error("not all gates open with both enables high");

  // Any closed request closes its gate at the next low reference
  property p_stop;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (!ref_level) |=> ((gate_vec & ~$past(run_vec)) == 6'h00);
  endproperty
  a_stop: assert property (p_stop)
    else $error("gate open without a run request");

  // Oscillator wake-up starts a settle period with all run requests low
  sequence s_wake;
    !osc_on_out ##1 osc_on_out;
  endsequence
  property p_settle;
    @(posedge mclk_in) disable iff (!rst_n_in)
      s_wake |-> settling_out ##1 (run_vec == 6'h00);
  endproperty
  a_settle: assert property (p_settle)
    else $error("outputs requested before oscillator settled");

endmodule

`default_nettype wire

// ### fanout_gate_pkg.sv
package fanout_gate_pkg;

  // Number of clock copies driven out
  localparam int NUM_OUTPUTS = 6;
  // Index of the separately gated copy (output_five)
  localparam int OUTPUT_FIVE_IDX = 5;

  // Variant codes: how the two enables govern outputs and oscillator
  localparam int VARIANT_BASE = 0;       // Global enable low stops everything
  localparam int VARIANT_KEEP_FIVE = 1;  // Output five may run alone
  localparam int VARIANT_OSC_ALWAYS = 2; // Oscillator never stops

  // Reference source select codes
  localparam bit REF_SRC_TTL = 1'b0;     // Logic-level clock input
  localparam bit REF_SRC_CRYSTAL = 1'b1; // Own crystal oscillator

  // Timing: system clock period and oscillator settle time
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_SETTLE_MS = 5;      // enable_latency for the global enable
  localparam int OSC_SETTLE_CYCLES = OSC_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 20;      // Wide enough for the settle count

  // Latencies in reference cycles for gating on and off
  localparam int ENABLE_LATENCY_REF = 4;  // enable_latency, last output enable
  localparam int DISABLE_LATENCY_REF = 4; // disable_latency, both enables

  // Reset values
  localparam bit SYNC_RESET_VAL = 1'b0;
  localparam bit GATE_RESET_VAL = 1'b0;

endpackage

// ### clk_gate_cell.sv
`timescale 1ns/1ps
`default_nettype none

// One glitch-free gate for one output copy. The gate control only moves
// while the reference is low, so a pulse is either passed whole or not at all.
module clk_gate_cell (
  input wire logic mclk_in,      // System clock
  input wire logic rst_n_in,     // Asynchronous reset, active low
  input wire logic ref_level_in, // Sampled reference level
  input wire logic run_in,       // Request to let this copy run
  output logic gate_out,         // Current gate state
  output logic clk_out           // Gated clock copy, from a flip-flop
);

  logic gate; // Gate control, frozen while reference is high
  logic clk_q; // Registered output level
  logic next_gate; // Gate value for the next edge

  // Hold the gate while reference is high; a flop stands in for the latch
  assign next_gate = ref_level_in ? gate : run_in;

  // Gate and output registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate <= fanout_gate_pkg::GATE_RESET_VAL;
      clk_q <= 1'b0;
    end else begin
      gate <= next_gate;
      clk_q <= ref_level_in & gate;
    end
  end

  assign gate_out = gate;
  assign clk_out = clk_q;

endmodule

`default_nettype wire

// ### crystal_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// Crystal oscillator as the block sees it. It swings only while enabled and,
// once disabled, finishes its high half and then stands low (no runt of its own).
module crystal_osc_model #(
  parameter int HALF = 4 // Half period in system clocks
) (
  input wire logic mclk_in,   // System clock
  input wire logic osc_on_in, // Oscillator enable, high runs
  output logic crystal_out    // Oscillator waveform
);
  int cnt = 0; // Position within the current half period

  initial crystal_out = 1'b0;

  // Swing on a grid of system clocks, changed just after each edge
  always @(posedge mclk_in) begin
    #1;
    if (crystal_out || osc_on_in) begin
      cnt = (cnt + 1) % HALF;
      if (cnt == 0) crystal_out = crystal_out ? 1'b0 : osc_on_in;
    end else begin
      cnt = 0; // Stopped: holds low
    end
  end
endmodule

`default_nettype wire

// ### six_output_clock_gate_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define check_eq(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t: got %0h expected %0h", $time, (a), (b)); end end

module six_output_clock_gate_bench;
  localparam int HALF = 4;   // Reference half period in system clocks
  localparam int SETTLE = 8; // Short settle count to keep the run brief
  logic mclk_in = 1'b0;      // System clock
  logic rst_n_in = 1'b0;     // Reset, active low
  logic g_en = 1'b1;         // Global run enable
  logic l_en = 1'b1;         // Last output enable
  wire ref_clk;              // Logic-level reference
  wire [3:0] xtal;           // One crystal per instance
  wire [3:0] osc;            // Oscillator enables
  wire [3:0] settle;         // Settling flags
  wire [23:0] fan;           // Six copies per instance
  logic [23:0] fan_q = '0;   // Copies one edge ago
  int run [24];              // Length of the current high pulse
  int rises [24];            // Rising edges in the window
  int err_total = 0;
  int cmp_count = 0;

  initial forever #5 mclk_in = ~mclk_in;

  crystal_osc_model #(.HALF(HALF)) u_crystal_osc_model (.mclk_in(mclk_in),
    .osc_on_in(1'b1), .crystal_out(ref_clk));

  // Three crystal-fed variants plus a base variant fed from the logic-level pin
  for (genvar i = 0; i < 4; i++) begin : g_var
    crystal_osc_model #(.HALF(HALF)) u_crystal_osc_model (.mclk_in(mclk_in),
      .osc_on_in(osc[i]), .crystal_out(xtal[i]));
    six_output_clock_gate #(.VARIANT(i % 3),
      .REF_SOURCE((i == 3) ? fanout_gate_pkg::REF_SRC_TTL : fanout_gate_pkg::REF_SRC_CRYSTAL),
      .SETTLE_CYCLES(SETTLE)) u_six_output_clock_gate (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .global_run_enable_in(g_en),
      .last_output_enable_in(l_en), .ref_clock_in(ref_clk), .crystal_input_in(xtal[i]),
      .fanout_clk_out(fan[6*i+:6]), .osc_on_out(osc[i]), .settling_out(settle[i]));
  end

  // Every high pulse must be a whole reference half; count rises too
  always @(posedge mclk_in) begin
    for (int k = 0; k < 24; k++) begin
      if (fan[k] === 1'b1) begin
        run[k]++;
        if (fan_q[k] !== 1'b1) rises[k]++;
      end else begin
        if (run[k] != 0) `check_eq(run[k], HALF)
        run[k] = 0;
      end
    end
    fan_q <= fan;
  end

  task automatic finish_test;
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic set_en(input logic g, input logic l);
    @(posedge mclk_in);
    #1;
    g_en = g;
    l_en = l;
  endtask

  // Let gating settle, then watch four reference periods
  task automatic measure(input logic g, input logic l);
    logic t;
    int w;
    repeat (32) @(posedge mclk_in);
    #1;
    rises = '{default: 0};
    repeat (32) @(posedge mclk_in);
    #1;
    for (int v = 0; v < 4; v++) begin
      w = v % 3;
      `check_eq(osc[v], (w == 2) || g || (w == 1 && l))
      `check_eq(settle[v], 1'b0)
      for (int b = 0; b < 6; b++) begin
        t = (b < 5) ? g : (l && (g || w > 0));
        if (b < 5) `check_eq(fan[6*v+b], fan[6*v])
        `check_eq(rises[6*v+b] > 0, t)
        `check_eq(fan[6*v+b] && !t, 1'b0)
      end
    end
  endtask

  task automatic test_both_high;
    set_en(1'b1, 1'b1);
    measure(1'b1, 1'b1);
  endtask

  task automatic test_global_only;
    set_en(1'b1, 1'b0);
    measure(1'b1, 1'b0);
  endtask

  task automatic test_last_only;
    set_en(1'b0, 1'b1);
    measure(1'b0, 1'b1);
  endtask

  task automatic test_both_low;
    set_en(1'b0, 1'b0);
    measure(1'b0, 1'b0);
  endtask

  // Waking the base variant: outputs stay low while the oscillator settles
  task automatic test_wake_settle;
    int n;
    set_en(1'b1, 1'b1);
    n = 0;
    while (osc[0] !== 1'b1 && n < 10) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    `check_eq(osc[0], 1'b1)
    repeat (5) begin
      @(posedge mclk_in);
      #1;
      `check_eq({settle[0], fan[5:0]}, 7'h40)
    end
    measure(1'b1, 1'b1);
  endtask

  // Enables flipped at odd spacing, landing inside reference pulses
  task automatic test_quick_flip;
    for (int i = 0; i < 8; i++) begin
      set_en(i[0], ~i[1]);
      repeat (6) @(posedge mclk_in);
    end
    set_en(1'b1, 1'b1);
    measure(1'b1, 1'b1);
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    test_both_high();
    test_global_only();
    test_last_only();
    test_both_low();
    test_wake_settle();
    test_quick_flip();
    finish_test();
  end

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge mclk_in);
    err_total++;
    finish_test();
  end
endmodule

`default_nettype wire
